// ==== tos_thermal_overload_stage.sv ====
/*
  Thermal overload stage: rms of phase currents, first order thermal model,
  start and trip with release hysteresis, ambient correction, counters,
  test force with timeout and estimated time to trip, all behind APB.
  Assumes phase samples, ambient inputs, block and the 1 s model tick come
  from logic on sys_clk.
*/
// Our own choices: the APB register port and the address map.
// Behaviour
// - rms to 15th harmonic, largest phase modelled
// - report highest phase rms current
// - temperature rise moves exponentially toward squared current ratio
// - limit is service factor, ambient factor, rated
// - trip when temperature rise reaches 100 percent
// - start when rise reaches alarm level
// - trip releases below sqrt 0.95 service current
// - start release further scaled by sqrt alarm
// - below 0.3 rated, cool with scaled constant
// - cooling coefficient defaults to 1.0
// - ambient factor one when compensation disabled
// - load at 40 defaults 100, 70 held
// - ambient source none or sixteen inputs
// - no sensor: editable ambient, default 40
// - power up temperature rise starts at 70
// - start and trip counters, clearable
// - force flag clears after five minutes
// - time to trip as hours minutes seconds
`timescale 1ns/1ps
module tos_thermal_overload_stage #(
  parameter longint FORCE_TIMEOUT = tos_pkg::FORCE_TIMEOUT_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire tos_pkg::tos_phase_s    phase_sample,
  input  wire logic [15:0][7:0]       external_analog_input,
  input  wire logic                   model_tick,
  input  wire logic                   stage_block,
  input  wire tos_pkg::tos_apb_req_s  apb_req,
  output tos_pkg::tos_apb_rsp_s       apb_rsp,
  output logic                        stage_start,
  output logic                        stage_trip
);
  import tos_pkg::*;

  typedef struct packed {
    tos_apb_rsp_s     rsp;
    logic             force_on;
    logic             f_start;
    logic             f_trip;
    logic [33:0]      force_cnt;
    logic [15:0]      sf;
    logic [7:0]       alarm;
    logic [15:0]      tau;
    logic [15:0]      ccoef;
    logic [7:0]       load40;
    logic [7:0]       load70;
    logic [4:0]       amb_sel;
    logic [7:0]       amb_temp;
    logic [2:0][37:0] acc;
    logic [4:0]       nsmp;
    logic [31:0]      ms;
    logic [15:0]      rms;
    logic [15:0]      limit;
    logic [31:0]      theta;
    logic [31:0]      target;
    tos_fsm_e         fsm;
    tos_div_s         div;
    logic [15:0]      hh;
    logic [7:0]       mm;
    logic [7:0]       ss;
    logic             start;
    logic             trip;
    logic             start_out;
    logic             trip_out;
    logic [15:0]      scnt;
    logic [15:0]      tcnt;
  } tos_state_s;

  tos_state_s         q;
  tos_state_s         d;

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [31:0] x;
    logic [31:0] r;
    logic [31:0] b;
    x = v;
    r = '0;
    b = 32'h4000_0000;
    for (int i = 0; i < 16; i++) begin
      if (x >= r + b) begin
        x = x - r - b;
        r = (r >> 1) + b;
      end else begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    return r[15:0];
  endfunction : isqrt

  // log2 of a Q16 value of at least 1.0, linear between octaves
  function automatic logic [31:0] log2_q16(input logic [31:0] r);
    logic [31:0] n;
    int          p;
    p = 16;
    for (int i = 17; i < 32; i++) begin
      if (r[i]) begin
        p = i;
      end
    end
    n = r >> (p - 16);
    return 32'((p - 16) << 16) | {16'h0000, n[15:0]};
  endfunction : log2_q16

  function automatic tos_div_s div_start(input logic [47:0] n,
                                         input logic [47:0] den);
    tos_div_s s;
    s.rem = '0;
    s.quo = n;
    s.den = (den == '0) ? 48'h0000_0000_0001 : den;
    s.cnt = 6'h30;
    return s;
  endfunction : div_start

  function automatic logic [31:0] sat32(input logic [47:0] v);
    return (|v[47:32]) ? 32'hFFFF_FFFF : v[31:0];
  endfunction : sat32

  logic               xfer;
  logic               wr;
  logic               hit;
  logic [31:0]        rd;
  logic [31:0]        w;
  logic [1:0]         stat;
  logic               clr_s;
  logic               clr_t;
  logic [37:0]        sum;
  logic signed [31:0] prod;
  logic [31:0]        mx;
  logic               amb_none;
  logic signed [7:0]  amb_c;
  int                 pct;
  int                 kth;
  longint             lim;
  logic [31:0]        imax2;
  logic [47:0]        rel_t;
  logic [47:0]        rel_s;
  logic [31:0]        alarm_lvl;
  logic [31:0]        tau_s;
  logic [31:0]        tau_c;
  logic [31:0]        tgt;
  logic [32:0]        th;
  logic [47:0]        lnv;
  logic [47:0]        t_s;
  logic [47:0]        t;

  always_comb begin
    d         = q;
    w         = apb_req.pwdata;
    hit       = 1'b1;
    rd        = '0;
    clr_s     = 1'b0;
    clr_t     = 1'b0;
    sum       = '0;
    prod      = '0;
    mx        = '0;
    tgt       = '0;
    th        = '0;
    lnv       = '0;
    t_s       = '0;
    t         = '0;
    amb_none = (q.amb_sel == 5'h00) || (32'(q.amb_sel) > AMB_INPUTS);

    // trip over start over blocked
    if (q.trip) begin
      stat = ST_TRIP;
    end else if (q.start) begin
      stat = ST_START;
    end else if (stage_block) begin
      stat = ST_BLOCK;
    end else begin
      stat = ST_IDLE;
    end

    case (apb_req.paddr)
      REG_CTRL:     rd = 32'({q.f_trip, q.f_start, q.force_on});
      REG_SF:       rd = 32'(q.sf);
      REG_ALARM:    rd = 32'(q.alarm);
      REG_TAU:      rd = 32'(q.tau);
      REG_CCOEF:    rd = 32'(q.ccoef);
      REG_LOAD40:   rd = 32'(q.load40);
      REG_LOAD70:   rd = 32'(q.load70);
      REG_AMB_SEL:  rd = 32'(q.amb_sel);
      REG_AMB_TEMP: rd = {{24{q.amb_temp[7]}}, q.amb_temp};
      REG_STATUS:   rd = 32'({q.trip, q.start, q.force_on, 2'h0, stat});
      REG_THETA:    rd = q.theta;
      REG_RMS:      rd = 32'(q.rms);
      REG_LIMIT:    rd = 32'(q.limit);
      REG_SCNT:     rd = 32'(q.scnt);
      REG_TCNT:     rd = 32'(q.tcnt);
      REG_TTRIP:    rd = {q.hh, q.mm, q.ss};
      default:      hit = 1'b0;
    endcase

    // one wait state, pready high for exactly one cycle
    xfer = apb_req.psel & apb_req.penable;
    if (xfer & ~q.rsp.pready) begin
      d.rsp.pready  = 1'b1;
      d.rsp.pslverr = ~hit;
      d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
    end else begin
      d.rsp.pready  = 1'b0;
      d.rsp.pslverr = 1'b0;
    end
    wr = xfer & q.rsp.pready & apb_req.pwrite;

    if (q.force_on) begin
      d.force_cnt = q.force_cnt + 34'h0_0000_0001;
      if (q.force_cnt == 34'(FORCE_TIMEOUT - 1)) begin
        d.force_on  = 1'b0;
        d.force_cnt = '0;
      end
    end

    if (wr) begin
      case (apb_req.paddr)
        REG_CTRL: begin
          d.force_on = w[CTRL_FORCE];
          d.f_start  = w[CTRL_FSTART];
          d.f_trip   = w[CTRL_FTRIP];
          if (w[CTRL_FORCE]) begin
            d.force_cnt = '0;
          end
          clr_s = w[CTRL_CLR_START];
          clr_t = w[CTRL_CLR_TRIP];
        end
        REG_SF:      d.sf = w[15:0];
        REG_ALARM:   d.alarm = w[7:0];
        REG_TAU:     d.tau = w[15:0];
        REG_CCOEF:   d.ccoef = w[15:0];
        REG_LOAD40:  d.load40 = w[7:0];
        REG_LOAD70:  d.load70 = w[7:0];
        REG_AMB_SEL: d.amb_sel = w[4:0];
        REG_AMB_TEMP: begin
          if (amb_none) begin
            d.amb_temp = w[7:0];
          end
        end
        default: ;
      endcase
    end

    // mean square over one period per phase, keep the largest
    if (phase_sample.valid) begin
      for (int p = 0; p < 3; p++) begin
        prod = $signed(phase_sample.cur[p]) * $signed(phase_sample.cur[p]);
        sum  = q.acc[p] + 38'(unsigned'(prod));
        d.acc[p] = sum;
        if (32'(sum >> RMS_LOG2) > mx) begin
          mx = 32'(sum >> RMS_LOG2);
        end
      end
      d.nsmp = q.nsmp + 5'h01;
      if (&q.nsmp) begin
        d.ms  = mx;
        d.acc = '0;
      end
    end
    d.rms = isqrt(q.ms);

    // ambient factor, linear between the 40 and 70 degree points
    amb_c = amb_none ? q.amb_temp
                     : external_analog_input[4'(q.amb_sel - 5'h01)];
    pct = int'(q.load40) + (int'(q.load70) - int'(q.load40))
          * (int'(amb_c) - AMB_REF_C) / (AMB_HI_C - AMB_REF_C);
    if (pct < 0) begin
      pct = 0;
    end
    if (amb_none || int'(q.load40) == PCT || int'(amb_c) == AMB_REF_C) begin
      kth = 1 << SET_FRAC;
    end else begin
      kth = pct * (1 << SET_FRAC) / PCT;
    end
    lim = (longint'(q.sf) * kth) >> (2 * SET_FRAC - CUR_FRAC);
    d.limit = (lim > 65535) ? 16'hFFFF : 16'(lim);
    imax2 = 32'(q.limit) * 32'(q.limit);

    rel_t = ((48'(q.sf) * 48'(q.sf) * REL_NUM) / REL_DEN)
            << (2 * CUR_FRAC - 2 * SET_FRAC);
    rel_s = (rel_t * 48'(q.alarm)) / PCT;
    alarm_lvl = 32'((32'(q.alarm) << TH_FRAC) / PCT);
    tau_s = 32'(q.tau) * 32'(SEC_PER_MIN);
    if (q.ms < COOL_MS) begin
      tau_c = 32'((48'(tau_s) * 48'(q.ccoef)) >> SET_FRAC);
    end else begin
      tau_c = tau_s;
    end

    if (q.theta >= TH_ONE) begin
      d.trip = 1'b1;
    end else if (48'(q.ms) < rel_t) begin
      d.trip = 1'b0;
    end
    if (q.theta >= alarm_lvl) begin
      d.start = 1'b1;
    end else if (48'(q.ms) < rel_s) begin
      d.start = 1'b0;
    end
    d.start_out = (d.start | (q.force_on & q.f_start)) & ~stage_block;
    d.trip_out  = (d.trip | (q.force_on & q.f_trip)) & ~stage_block;

    // an event in the clear cycle still counts
    if (clr_s) begin
      d.scnt = '0;
    end
    if (d.start & ~q.start) begin
      d.scnt = d.scnt + 16'h0001;
    end
    if (clr_t) begin
      d.tcnt = '0;
    end
    if (d.trip & ~q.trip) begin
      d.tcnt = d.tcnt + 16'h0001;
    end

    // shared restoring divider, one quotient bit per cycle
    if (q.div.cnt != 6'h00) begin
      t = {q.div.rem[46:0], q.div.quo[47]};
      d.div.quo = {q.div.quo[46:0], 1'b0};
      if (t >= q.div.den) begin
        t = t - q.div.den;
        d.div.quo[0] = 1'b1;
      end
      d.div.rem = t;
      d.div.cnt = q.div.cnt - 6'h01;
    end else begin
      case (q.fsm)
        FS_IDLE: begin
          if (model_tick) begin
            d.div = div_start(48'(q.ms) << TH_FRAC, 48'(imax2));
            d.fsm = FS_TARGET;
          end
        end
        FS_TARGET: begin
          tgt = sat32(q.div.quo);
          d.target = tgt;
          d.div = div_start((tgt >= q.theta) ? 48'(tgt - q.theta)
                                             : 48'(q.theta - tgt),
                            48'(tau_c));
          d.fsm = FS_STEP;
        end
        FS_STEP: begin
          if (q.target >= q.theta) begin
            th = 33'(q.theta) + 33'(sat32(q.div.quo));
          end else begin
            th = 33'(q.theta) - 33'(sat32(q.div.quo));
          end
          if (th[32]) begin
            th = (q.target >= q.theta) ? 33'h0_FFFF_FFFF : 33'h0_0000_0000;
          end
          d.theta = th[31:0];
          if (th[31:0] >= TH_ONE) begin
            d.hh  = '0;
            d.mm  = '0;
            d.ss  = '0;
            d.fsm = FS_IDLE;
          end else if (q.target > TH_ONE) begin
            d.div = div_start(48'(q.target - th[31:0]) << TH_FRAC,
                              48'(q.target - TH_ONE));
            d.fsm = FS_RATIO;
          end else begin
            d.hh  = '1;
            d.mm  = '1;
            d.ss  = '1;
            d.fsm = FS_IDLE;
          end
        end
        FS_RATIO: begin
          lnv = (48'(log2_q16(sat32(q.div.quo))) * 48'(LN2_Q16))
                >> TH_FRAC;
          t_s = (48'(tau_s) * lnv) >> TH_FRAC;
          d.div = div_start(t_s, 48'(SEC_PER_HOUR));
          d.fsm = FS_HOURS;
        end
        FS_HOURS: begin
          d.hh  = (|q.div.quo[47:16]) ? 16'hFFFF : q.div.quo[15:0];
          d.div = div_start(q.div.rem, 48'(SEC_PER_MIN));
          d.fsm = FS_MINS;
        end
        FS_MINS: begin
          d.mm  = q.div.quo[7:0];
          d.ss  = q.div.rem[7:0];
          d.fsm = FS_IDLE;
        end
        default: d.fsm = FS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.sf       <= RST_SF;
      q.alarm    <= RST_ALARM;
      q.tau      <= RST_TAU;
      q.ccoef    <= RST_CCOEF;
      q.load40   <= RST_LOAD40;
      q.load70   <= RST_LOAD70;
      q.amb_temp <= RST_AMB_TEMP;
      q.theta    <= TH_INIT;
      q.fsm      <= FS_IDLE;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign apb_rsp     = q.rsp;
  assign stage_start = q.start_out;
  assign stage_trip  = q.trip_out;

endmodule : tos_thermal_overload_stage

// ==== tos_pkg.sv ====
/*
  Constants, carrier types and state enumerations shared by the thermal
  overload stage. Assumes a 40 MHz system clock and phase samples scaled so
  that 1.0 x rated current equals 2**12.
*/
package tos_pkg;

  localparam int          CLK_HZ            = 40_000_000;
  localparam int          FORCE_TIMEOUT_MIN = 5;
  localparam int          SEC_PER_MIN       = 60;
  localparam int          SEC_PER_HOUR      = 3600;
  localparam longint      FORCE_TIMEOUT_CYC =
    longint'(FORCE_TIMEOUT_MIN) * SEC_PER_MIN * CLK_HZ;

  // fixed point scales
  localparam int          CUR_FRAC    = 12;
  localparam int          SET_FRAC    = 8;
  localparam int          TH_FRAC     = 16;
  localparam logic [31:0] TH_ONE      = 32'h0001_0000;
  localparam int          PCT         = 100;
  localparam int          TH_INIT_PCT = 70;
  localparam logic [31:0] TH_INIT     = 32'((TH_INIT_PCT << TH_FRAC) / PCT);
  localparam int          LN2_Q16     = 45426;

  // 32 samples per period keep harmonics up to the 15th
  localparam int          RMS_LOG2    = 5;
  localparam int          COOL_NUM    = 3;
  localparam int          COOL_DEN    = 10;
  localparam logic [31:0] COOL_MS     = 32'((COOL_NUM * COOL_NUM
    << (2 * CUR_FRAC)) / (COOL_DEN * COOL_DEN));
  localparam int          REL_NUM     = 95;
  localparam int          REL_DEN     = 100;
  localparam int          AMB_REF_C   = 40;
  localparam int          AMB_HI_C    = 70;
  localparam int          AMB_INPUTS  = 16;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_SF       = 8'h04;
  localparam logic [7:0]  REG_ALARM    = 8'h08;
  localparam logic [7:0]  REG_TAU      = 8'h0C;
  localparam logic [7:0]  REG_CCOEF    = 8'h10;
  localparam logic [7:0]  REG_LOAD40   = 8'h14;
  localparam logic [7:0]  REG_LOAD70   = 8'h18;
  localparam logic [7:0]  REG_AMB_SEL  = 8'h1C;
  localparam logic [7:0]  REG_AMB_TEMP = 8'h20;
  localparam logic [7:0]  REG_STATUS   = 8'h24;
  localparam logic [7:0]  REG_THETA    = 8'h28;
  localparam logic [7:0]  REG_RMS      = 8'h2C;
  localparam logic [7:0]  REG_LIMIT    = 8'h30;
  localparam logic [7:0]  REG_SCNT     = 8'h34;
  localparam logic [7:0]  REG_TCNT     = 8'h38;
  localparam logic [7:0]  REG_TTRIP    = 8'h3C;

  // control bits
  localparam int          CTRL_FORCE     = 0;
  localparam int          CTRL_FSTART    = 1;
  localparam int          CTRL_FTRIP     = 2;
  localparam int          CTRL_CLR_START = 8;
  localparam int          CTRL_CLR_TRIP  = 9;

  // reset values
  localparam logic [15:0] RST_SF       = 16'h0100;
  localparam logic [7:0]  RST_ALARM    = 8'h50;
  localparam logic [15:0] RST_TAU      = 16'h001E;
  localparam logic [15:0] RST_CCOEF    = 16'h0100;
  localparam logic [7:0]  RST_LOAD40   = 8'h64;
  localparam logic [7:0]  RST_LOAD70   = 8'h64;
  localparam logic [7:0]  RST_AMB_TEMP = 8'h28;

  // status codes
  localparam logic [1:0]  ST_IDLE  = 2'h0;
  localparam logic [1:0]  ST_BLOCK = 2'h1;
  localparam logic [1:0]  ST_START = 2'h2;
  localparam logic [1:0]  ST_TRIP  = 2'h3;

  typedef enum logic [2:0] {
    FS_IDLE, FS_TARGET, FS_STEP, FS_RATIO, FS_HOURS, FS_MINS
  } tos_fsm_e;

  typedef struct packed {
    logic             valid;
    logic [2:0][15:0] cur;
  } tos_phase_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tos_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tos_apb_rsp_s;

  typedef struct packed {
    logic [47:0] rem;
    logic [47:0] quo;
    logic [47:0] den;
    logic [5:0]  cnt;
  } tos_div_s;

endpackage : tos_pkg

// ==== tos_properties.sv ====
/*
  Checker for the thermal overload stage: APB timing and output gating.
  Bound to every stage instance; one sys_clk domain, rst_n async low.
*/
`timescale 1ns/1ps
module tos_properties
  import tos_pkg::*;
#(
  parameter longint FORCE_TIMEOUT = FORCE_TIMEOUT_CYC
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire tos_pkg::tos_phase_s   phase_sample,
  input wire logic [15:0][7:0]      external_analog_input,
  input wire logic                  model_tick,
  input wire logic                  stage_block,
  input wire tos_pkg::tos_apb_req_s apb_req,
  input wire tos_pkg::tos_apb_rsp_s apb_rsp,
  input wire logic                  stage_start,
  input wire logic                  stage_trip
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property ($rose(rst_n) |->
    !stage_start && !stage_trip && !apb_rsp.pready)
    else $error("outputs active right after reset");
  a_block_gates: assert property (
    clk_en && stage_block |=> !stage_start && !stage_trip)
    else $error("output active while blocked");
  a_ready_needs_access: assert property (
    !(apb_req.psel && apb_req.penable) |=> !apb_rsp.pready)
    else $error("pready without access phase");
  a_ready_one_wait: assert property (clk_en && apb_req.psel &&
    apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_err_reads_zero: assert property (apb_rsp.pslverr &&
    !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_holds: assert property (
    !apb_rsp.pready |-> $stable(apb_rsp.prdata))
    else $error("prdata changed outside pready");
endmodule : tos_properties

bind tos_thermal_overload_stage tos_properties #(
  .FORCE_TIMEOUT(FORCE_TIMEOUT)
) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .phase_sample(phase_sample),
  .external_analog_input(external_analog_input),
  .model_tick(model_tick), .stage_block(stage_block),
  .apb_req(apb_req), .apb_rsp(apb_rsp),
  .stage_start(stage_start), .stage_trip(stage_trip)
);

// ==== tos_phase_source.sv ====
/*
  Partner model: phase current samples and ambient sensor inputs.
  Levels come from the bench; one sample every fourth sys_clk cycle.
*/
`timescale 1ns/1ps
module tos_phase_source
  import tos_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [2:0][15:0] level,
  input  wire logic [7:0]       amb_c,
  output tos_pkg::tos_phase_s   phase_sample,
  output logic      [15:0][7:0] external_analog_input
);
  logic [1:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= 2'h0;
      phase_sample <= '0;
    end else begin
      cnt_q              <= cnt_q + 2'h1;
      phase_sample.valid <= (cnt_q == 2'h0);
      // data off the strobe is scrambled so it cannot be taken
      phase_sample.cur   <= (cnt_q == 2'h0) ? level : ~level;
    end
  end
  // only input sixteen carries the real ambient, the rest read 20 C warmer
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      external_analog_input[i] = (i == 15) ? amb_c : amb_c + 8'h14;
    end
  end
endmodule : tos_phase_source

// ==== tb_top.sv ====
/*
  Testbench: APB register tests and thermal model scenarios.
  Assumes the partner model feeds phase samples and ambient inputs.
*/
`timescale 1ns/1ps
module tb_top;
  import tos_pkg::*;
  logic             sys_clk, rst_n, clk_en, tick, blk, st, tr;
  tos_apb_req_s     req;
  tos_apb_rsp_s     rsp;
  tos_phase_s       ph;
  logic [15:0][7:0] ext;
  logic [2:0][15:0] lvl;
  logic [7:0]       amb;
  int               num_errors, tests_run;
  logic [7:0]  ra [10] = '{REG_SF, REG_ALARM, REG_TAU, REG_CCOEF,
    REG_LOAD40, REG_LOAD70, REG_AMB_SEL, REG_AMB_TEMP, REG_THETA, REG_SCNT};
  logic [31:0] rv [10] = '{32'h100, 32'h50, 32'h1E, 32'h100, 32'h64,
    32'h64, 32'h0, 32'h28, 32'hB333, 32'h0};

  tos_thermal_overload_stage #(.FORCE_TIMEOUT(200)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .phase_sample(ph), .external_analog_input(ext), .model_tick(tick),
    .stage_block(blk), .apb_req(req), .apb_rsp(rsp),
    .stage_start(st), .stage_trip(tr));
  tos_phase_source u_src (.sys_clk(sys_clk), .rst_n(rst_n), .level(lvl),
    .amb_c(amb), .phase_sample(ph), .external_analog_input(ext));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    r = rsp.prdata;
    e = rsp.pslverr;
    if (n >= 20) num_errors++;
    req <= '0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), r, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge sys_clk) tick <= 1'b1;
      @(posedge sys_clk) tick <= 1'b0;
      repeat (300) @(posedge sys_clk);
    end
  endtask : tk

  // L2 negative and largest, the other phases smaller
  task automatic setc(input logic [15:0] v);
    lvl <= {v >> 2, -v, v >> 1};
  endtask : setc

  task automatic up(input bit t);
    int n;
    n = 0;
    while ((t ? tr : st) !== 1'b1 && n < 80) begin
      tk(1);
      n++;
    end
    if (n >= 80) num_errors++;
  endtask : up

  task automatic fall(input logic [31:0] lim);
    int          n;
    logic [31:0] r;
    logic        e;
    n = 0;
    do begin
      tk(1);
      apb(1'b0, REG_THETA, 32'h0, r, e);
      n++;
    end while (r >= lim && n < 80);
    if (n >= 80) num_errors++;
  endtask : fall

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (95000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    rst_n = 1'b0; clk_en = 1'b1; tick = 1'b0; blk = 1'b0;
    req = '0; lvl = '0; amb = 8'h28; num_errors = 0; tests_run = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", e, 1'b1);
    wr(REG_THETA, 32'h0);
    rd(REG_THETA, 32'hB333);
    $display("test reset done");
    wr(REG_LOAD40, 32'h5A);
    wr(REG_AMB_TEMP, 32'h1E);
    rd(REG_AMB_TEMP, 32'h1E);
    tk(1);
    rd(REG_LIMIT, 32'h1000);
    wr(REG_AMB_SEL, 32'h10);
    tk(1);
    rd(REG_LIMIT, 32'h1000);
    amb <= 8'h37;
    rd(REG_LIMIT, 32'hF30);
    wr(REG_AMB_SEL, 32'h0);
    wr(REG_LOAD40, 32'h64);
    wr(REG_AMB_TEMP, 32'h28);
    $display("test ambient done");
    wr(REG_TAU, 32'h1);
    wr(REG_ALARM, 32'h48);
    setc(16'h1000);
    up(1'b0);
    chk("start set", st, 1'b1);
    setc(16'h0D48);
    fall(32'hB851);
    chk("start held", st, 1'b1);
    setc(16'h0800);
    tk(1);
    chk("start released", st, 1'b0);
    $display("test start done");
    setc(16'h1800);
    tk(2);
    apb(1'b0, REG_TTRIP, 32'h0, r, e);
    chk("time to trip", r < 32'h24 && r != 32'h0, 1'b1);
    up(1'b1);
    chk("trip set", tr, 1'b1);
    rd(REG_RMS, 32'h1800);
    rd(REG_STATUS, 32'h63);
    rd(REG_TTRIP, 32'h0);
    setc(16'h0FAE);
    fall(32'h10000);
    chk("trip held", tr, 1'b1);
    setc(16'h0F5C);
    tk(1);
    chk("trip released", tr, 1'b0);
    chk("start kept", st, 1'b1);
    rd(REG_SCNT, 32'h2);
    rd(REG_TCNT, 32'h1);
    wr(REG_CTRL, 32'h300);
    rd(REG_SCNT, 32'h0);
    rd(REG_TCNT, 32'h0);
    $display("test trip done");
    setc(16'h0000);
    fall(32'hB851);
    chk("start cooled", st, 1'b0);
    wr(REG_CCOEF, 32'h200);
    apb(1'b0, REG_THETA, 32'h0, r, e);
    tk(1);
    rd(REG_THETA, r - r / 120);
    clk_en <= 1'b0;
    tk(1);
    clk_en <= 1'b1;
    rd(REG_THETA, r - r / 120);
    $display("test cooling done");
    wr(REG_CTRL, 32'h5);
    repeat (2) @(posedge sys_clk);
    chk("forced trip", tr, 1'b1);
    blk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("blocked trip", tr, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    chk("status code", r[1:0], ST_BLOCK);
    blk <= 1'b0;
    repeat (150) @(posedge sys_clk);
    chk("force kept", tr, 1'b1);
    repeat (60) @(posedge sys_clk);
    chk("force expired", tr, 1'b0);
    rd(REG_CTRL, 32'h4);
    $display("test force done");
    wrap_up();
  end
endmodule : tb_top
